// file: verilog/crs_pkg.sv
// Purpose: Shared constants and types for the CAN receive buffer and sleep control
// Assumes: Byte-wide register port with printed byte addresses
// Notes: Dominant bus level is coded as 0 everywhere
package crs_pkg;

   // Register map
   localparam logic [7:0] ADDR_CMD           = 8'h21;
   localparam logic [7:0] ADDR_STAT          = 8'h22;
   localparam logic [7:0] ADDR_RX_ID_HIGH    = 8'h34;
   localparam logic [7:0] ADDR_RX_FTL        = 8'h35;
   localparam logic [7:0] ADDR_RX_DATA_FIRST = 8'h36;
   localparam logic [7:0] ADDR_RX_DATA_LAST  = 8'h3d;

   // Command register fields
   localparam int CMD_SLEEP_BIT   = 0;
   localparam int CMD_L0P_BIT     = 1;
   localparam int CMD_L1P_BIT     = 2;
   localparam int CMD_REF_SEL_BIT = 3;

   // Status register fields
   localparam int STAT_ASLEEP_BIT  = 0;
   localparam int STAT_BUF_SEL_BIT = 1;

   // Frame-type and length register fields
   localparam int FTL_ID_LSB  = 5;
   localparam int FTL_RTR_BIT = 4;

   // Bus levels and sizes
   localparam logic       DOMINANT       = 1'b0;
   localparam logic       RECESSIVE      = 1'b1;
   localparam logic [3:0] DLC_MAX        = 4'h8;
   localparam int         DATA_BYTES     = 8;
   localparam logic [7:0] RD_IDLE        = 8'h00;

   // Cycles between processor stop and oscillator halt
   localparam logic [7:0] OSC_STOP_DELAY_CYC = 8'h10;

   typedef struct packed {
      logic [10:0]     id;
      logic            rtr;
      logic [3:0]      dlc;
      logic [7:0][7:0] data;
   } crs_frame_t;

   typedef struct packed {
      logic ref_sel;
      logic l1_passive;
      logic l0_passive;
   } crs_cmd_t;

   localparam crs_cmd_t CMD_RESET = 3'h0;

   typedef enum logic [3:0] {
      ST_AWAKE    = 4'b0001,
      ST_ASLEEP   = 4'b0010,
      ST_OSC_WAIT = 4'b0100,
      ST_OSC_OFF  = 4'b1000
   } crs_sleep_state_t;

endpackage

// file: verilog/crs_rx_set.sv
// Purpose: One complete receive buffer set
// Assumes: Written in one cycle by the swap logic
// Notes: Contents are not reset; only bytes within the length count are stored
`timescale 1ns/100ps
module crs_rx_set
   import crs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       ce,
   input  wire logic       we,
   input  wire crs_frame_t frame_in,
   output crs_frame_t      frame_q
);

   logic [3:0] count;

   // Remote frames carry no data; longer codes saturate at eight bytes
   always_comb begin
      if (frame_in.rtr) begin
         count = 4'h0;
      end else if (frame_in.dlc > DLC_MAX) begin
         count = DLC_MAX;
      end else begin
         count = frame_in.dlc;
      end
   end

   always_ff @(posedge clk) begin
      if (ce && we) begin
         frame_q.id  <= frame_in.id;
         frame_q.rtr <= frame_in.rtr;
         frame_q.dlc <= frame_in.dlc;
         for (int i = 0; i < DATA_BYTES; i++) begin
            if (4'(i) < count) begin
               frame_q.data[i] <= frame_in.data[i];
            end
         end
      end
   end

endmodule

// file: verilog/crs_ctrl.sv
// Purpose: CAN receive buffer window, one-wire fallback and sleep control
// Assumes: All inputs synchronous to clk; bus inputs code dominant as 0
// Notes: The block itself keeps running in sleep so it can see wake-up activity
// Function
// - Frame-type/length register: id bits 2..0 at 7..5, remote flag 4, length 3..0.
// - Eight byte registers hold received data, one byte each, undefined after reset.
// - Two receive sets behind one window, swapped by hardware on each frame.
// - Any dominant driver wins the resolved bus value.
// - Dominant is logic 0, recessive is logic 1.
// - Passive bits move each comparator input from its wire to half supply.
// - Sleep request enters sleep only when idle, else stays awake with wake interrupt.
// - Bus activity or a pending interrupt counts as active.
// - Clearing sleep request wakes the block without a wake interrupt.
// - Sleep request bit is write-only and always reads as zero.
// - Asleep flag is set while asleep and cleared on waking.
// - Both transmit outputs go high-impedance on entering sleep.
// - In sleep the active comparator is off and the sleep comparator watches.
// - Sleep stops block clocks only; processor stop stops processor clocks only.
// - Oscillator stops only when asleep and processor stopped.
// - Waking during the stop delay cancels the oscillator halt.
// - Dominant level while asleep wakes the block with a wake interrupt.
// - Reference select picks active inputs or half-supply compare for sleep detection.
// - Identifier high register holds id bits 10..3 of the 11-bit identifier.
// - Length code gives 0 to 8 data bytes; remote frames carry none.
// - Identifier high register sits just before the frame-type/length register.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module crs_ctrl
   import crs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       ce,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic      [7:0] rd_data,
   input  wire logic       rx_frame_valid,
   input  wire crs_frame_t rx_frame,
   input  wire logic       line0_in,
   input  wire logic       line1_in,
   input  wire logic       sleep_cmp0_in,
   input  wire logic       sleep_cmp1_in,
   input  wire logic       irq_pending,
   input  wire logic       tx_bit0,
   input  wire logic       tx_bit1,
   input  wire logic       tx_drive0,
   input  wire logic       tx_drive1,
   input  wire logic       cpu_stop,
   output logic            rx_bit,
   output logic            line0_to_ref,
   output logic            line1_to_ref,
   output logic            sleep_ref_select,
   output logic            active_cmp_en,
   output logic            sleep_cmp_en,
   output logic            can_asleep_flag,
   output logic            wake_irq,
   output logic            can_clk_en,
   output logic            cpu_clk_en,
   output logic            osc_stop,
   output logic            tx_line0_out,
   output logic            tx_line0_oe,
   output logic            tx_line1_out,
   output logic            tx_line1_oe
);

   crs_cmd_t         cmd;
   crs_sleep_state_t state;
   crs_sleep_state_t next_state;
   logic             next_wake;
   logic             buf_sel;
   logic [7:0]       osc_cnt;
   crs_frame_t       set0_q;
   crs_frame_t       set1_q;
   crs_frame_t       vis;
   logic             resolved;
   logic             sleep_dom;
   logic             cmd_wr;
   logic             sleep_wr;
   logic             wake_wr;
   logic             active;
   logic             awake_next;
   logic [2:0]       byte_idx;
   logic             in_data;

   // Command register: sleep request itself is not stored, only acted on
   assign cmd_wr   = wr_en && (addr == ADDR_CMD);
   assign sleep_wr = cmd_wr && wr_data[CMD_SLEEP_BIT];
   assign wake_wr  = cmd_wr && !wr_data[CMD_SLEEP_BIT];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cmd <= CMD_RESET;
      end else if (ce && cmd_wr) begin
         cmd.l0_passive <= wr_data[CMD_L0P_BIT];
         cmd.l1_passive <= wr_data[CMD_L1P_BIT];
         cmd.ref_sel    <= wr_data[CMD_REF_SEL_BIT];
      end
   end

   // A line moved to the reference no longer votes in the resolution
   always_comb begin
      if (cmd.l0_passive && cmd.l1_passive) begin
         resolved = RECESSIVE;
      end else if (cmd.l0_passive) begin
         resolved = line1_in;
      end else if (cmd.l1_passive) begin
         resolved = line0_in;
      end else begin
         resolved = line0_in & line1_in;
      end
   end

   // Half-supply compare keeps wake-up alive when one wire is shorted
   always_comb begin
      if (cmd.ref_sel) begin
         sleep_dom = (sleep_cmp0_in == DOMINANT) || (sleep_cmp1_in == DOMINANT);
      end else begin
         sleep_dom = (resolved == DOMINANT);
      end
   end

   assign active = (resolved == DOMINANT) || irq_pending;

   // Sleep sequencing
   always_comb begin
      next_state = state;
      next_wake  = 1'b0;
      case (state)
         ST_AWAKE: begin
            if (sleep_wr) begin
               if (active) begin
                  next_wake = 1'b1;
               end else begin
                  next_state = ST_ASLEEP;
               end
            end
         end
         ST_ASLEEP, ST_OSC_WAIT, ST_OSC_OFF: begin
            if (wake_wr) begin
               next_state = ST_AWAKE;
            end else if (sleep_dom) begin
               next_state = ST_AWAKE;
               next_wake  = 1'b1;
            end else if (!cpu_stop) begin
               next_state = ST_ASLEEP;
            end else if (state == ST_ASLEEP) begin
               next_state = ST_OSC_WAIT;
            end else if (osc_cnt == OSC_STOP_DELAY_CYC) begin
               next_state = ST_OSC_OFF;
            end
         end
         default: begin
            next_state = ST_AWAKE;
         end
      endcase
   end

   assign awake_next = (next_state == ST_AWAKE);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_AWAKE;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // Delay between processor stop and oscillator halt
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         osc_cnt <= 8'h00;
      end else if (ce) begin
         if (next_state == ST_OSC_WAIT) begin
            osc_cnt <= osc_cnt + 8'h01;
         end else begin
            osc_cnt <= 8'h00;
         end
      end
   end

   // All sleep-dependent outputs switch in the same cycle as the state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         can_asleep_flag <= 1'b0;
         wake_irq        <= 1'b0;
         can_clk_en      <= 1'b1;
         active_cmp_en   <= 1'b1;
         sleep_cmp_en    <= 1'b0;
         osc_stop        <= 1'b0;
      end else if (ce) begin
         can_asleep_flag <= !awake_next;
         wake_irq        <= next_wake;
         can_clk_en      <= awake_next;
         active_cmp_en   <= awake_next;
         sleep_cmp_en    <= !awake_next;
         osc_stop        <= (next_state == ST_OSC_OFF);
      end
   end

   // Processor stop never touches the block clocks
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cpu_clk_en <= 1'b1;
      end else if (ce) begin
         cpu_clk_en <= !cpu_stop;
      end
   end

   // Comparator routing and resolved receive bit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         line0_to_ref     <= 1'b0;
         line1_to_ref     <= 1'b0;
         sleep_ref_select <= 1'b0;
         rx_bit           <= RECESSIVE;
      end else if (ce) begin
         line0_to_ref     <= cmd.l0_passive;
         line1_to_ref     <= cmd.l1_passive;
         sleep_ref_select <= cmd.ref_sel;
         rx_bit           <= resolved;
      end
   end

   // Drivers float in sleep regardless of what the transmitter asks
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_line0_out <= RECESSIVE;
         tx_line1_out <= RECESSIVE;
         tx_line0_oe  <= 1'b0;
         tx_line1_oe  <= 1'b0;
      end else if (ce) begin
         tx_line0_out <= tx_bit0;
         tx_line1_out <= tx_bit1;
         tx_line0_oe  <= tx_drive0 && awake_next;
         tx_line1_oe  <= tx_drive1 && awake_next;
      end
   end

   // Double buffer: new frame goes to the hidden set, then the window flips
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         buf_sel <= 1'b0;
      end else if (ce && rx_frame_valid) begin
         buf_sel <= !buf_sel;
      end
   end

   crs_rx_set u_set0 (
      .clk      (clk),
      .ce       (ce),
      .we       (rx_frame_valid && buf_sel),
      .frame_in (rx_frame),
      .frame_q  (set0_q)
   );

   crs_rx_set u_set1 (
      .clk      (clk),
      .ce       (ce),
      .we       (rx_frame_valid && !buf_sel),
      .frame_in (rx_frame),
      .frame_q  (set1_q)
   );

   assign vis = buf_sel ? set1_q : set0_q;

   // Read port; receive registers have no write path at all
   assign in_data  = (addr >= ADDR_RX_DATA_FIRST) && (addr <= ADDR_RX_DATA_LAST);
   assign byte_idx = 3'(addr - ADDR_RX_DATA_FIRST);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= RD_IDLE;
      end else if (ce) begin
         rd_data <= RD_IDLE;
         if (rd_en) begin
            if (addr == ADDR_CMD) begin
               rd_data[CMD_L0P_BIT]     <= cmd.l0_passive;
               rd_data[CMD_L1P_BIT]     <= cmd.l1_passive;
               rd_data[CMD_REF_SEL_BIT] <= cmd.ref_sel;
            end else if (addr == ADDR_STAT) begin
               rd_data[STAT_ASLEEP_BIT]  <= can_asleep_flag;
               rd_data[STAT_BUF_SEL_BIT] <= buf_sel;
            end else if (addr == ADDR_RX_ID_HIGH) begin
               rd_data <= vis.id[10:3];
            end else if (addr == ADDR_RX_FTL) begin
               rd_data <= {vis.id[2:0], vis.rtr, vis.dlc};
            end else if (in_data) begin
               rd_data <= vis.data[byte_idx];
            end
         end
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_sleep_unreadable;
      (ce && rd_en && addr == ADDR_CMD) |=> !rd_data[CMD_SLEEP_BIT];
   endproperty
   a_sleep_unreadable: assert property (p_sleep_unreadable)
      else $error("sleep request bit visible on read");

   property p_tx_float;
      can_asleep_flag |-> (!tx_line0_oe && !tx_line1_oe);
   endproperty
   a_tx_float: assert property (p_tx_float)
      else $error("transmit driver enabled while asleep");

   property p_cmp_swap;
      can_asleep_flag |-> (!active_cmp_en && sleep_cmp_en && !can_clk_en);
   endproperty
   a_cmp_swap: assert property (p_cmp_swap)
      else $error("comparator or clock not switched in sleep");

   property p_osc_needs_sleep;
      osc_stop |-> (can_asleep_flag && $past(cpu_stop));
   endproperty
   a_osc_needs_sleep: assert property (p_osc_needs_sleep)
      else $error("oscillator stopped without sleep and stop");

   property p_wake_no_osc;
      wake_irq |-> (!osc_stop && !can_asleep_flag);
   endproperty
   a_wake_no_osc: assert property (p_wake_no_osc)
      else $error("oscillator stopped while waking");

   property p_busy_refuse;
      (ce && state == ST_AWAKE && sleep_wr && active)
         |=> (wake_irq && !can_asleep_flag);
   endproperty
   a_busy_refuse: assert property (p_busy_refuse)
      else $error("busy block went to sleep");

   property p_quiet_wake;
      (ce && state != ST_AWAKE && wake_wr) |=> (!wake_irq && !can_asleep_flag);
   endproperty
   a_quiet_wake: assert property (p_quiet_wake)
      else $error("software wake raised an interrupt");

   property p_bus_wake;
      (ce && state != ST_AWAKE && !cmd_wr && sleep_dom) |=> (wake_irq && !can_asleep_flag);
   endproperty
   a_bus_wake: assert property (p_bus_wake)
      else $error("dominant level did not wake the block");

   property p_swap;
      (ce && rx_frame_valid) |=> (buf_sel != $past(buf_sel));
   endproperty
   a_swap: assert property (p_swap)
      else $error("buffer sets not swapped on new frame");

   property p_dominant_wins;
      (ce && !cmd.l0_passive && !cmd.l1_passive && (!line0_in || !line1_in))
         |=> (rx_bit == DOMINANT);
   endproperty
   a_dominant_wins: assert property (p_dominant_wins)
      else $error("dominant driver lost resolution");

endmodule

// file: dv/crs_bus_node.sv
// Purpose: Far-side CAN nodes, wires and frame source for the bench
// Assumes: Block bus inputs code dominant as 0
// Notes: Frame bus shows inverted data outside the valid pulse
`timescale 1ns/100ps
module crs_bus_node
   import crs_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  node_dom,
   input  wire logic  stuck0,
   input  wire logic  stuck1,
   input  wire logic  cmp_blind,
   input  wire logic  tx0_out,
   input  wire logic  tx0_oe,
   input  wire logic  tx1_out,
   input  wire logic  tx1_oe,
   output logic       line0,
   output logic       line1,
   output logic       cmp0,
   output logic       cmp1,
   output logic       frame_valid,
   output crs_frame_t frame
);
   // Any dominant driver pulls the wire low, the block's own driver too
   assign line0 = !node_dom && (!tx0_oe || tx0_out) && !stuck0;
   assign line1 = !node_dom && (!tx1_oe || tx1_out) && !stuck1;
   // A weak swing may stay above half supply, so the sleep compare misses it
   assign cmp0 = line0 || cmp_blind;
   assign cmp1 = line1 || cmp_blind;
   initial begin
      frame_valid = 1'b0;
      frame = '0;
   end
   task automatic send(input crs_frame_t f);
      @(posedge clk);
      frame <= f;
      frame_valid <= 1'b1;
      @(posedge clk);
      frame <= ~f;
      frame_valid <= 1'b0;
      #1;
   endtask
endmodule

// file: dv/crs_ctrl_tb.sv
// Purpose: Self-checking bench for the receive window and sleep control
// Assumes: Registered outputs settle one cycle after the causing edge
// Notes: First two frames fill both receive sets so no byte is undefined
`timescale 1ns/100ps
module crs_ctrl_tb
   import crs_pkg::*;
;
   logic clk, resetn, ce, wr_en, rd_en, irq_pending, cpu_stop;
   logic tx_bit0, tx_bit1, tx_drive0, tx_drive1, node_dom, stuck0, stuck1, cmp_blind;
   logic [7:0] addr, wr_data, rd_data, d;
   logic rx_frame_valid, line0_in, line1_in, sleep_cmp0_in, sleep_cmp1_in;
   logic rx_bit, line0_to_ref, line1_to_ref, sleep_ref_select, active_cmp_en;
   logic sleep_cmp_en, can_asleep_flag, wake_irq, can_clk_en, cpu_clk_en;
   logic osc_stop, tx_line0_out, tx_line0_oe, tx_line1_out, tx_line1_oe;
   crs_frame_t rx_frame, f;
   logic [7:0] exp_set[2][8];
   logic       vis;
   int         bad_count, checks_done, n;

   crs_ctrl i_dut (.clk, .resetn, .ce, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
      .rx_frame_valid, .rx_frame, .line0_in, .line1_in, .sleep_cmp0_in,
      .sleep_cmp1_in, .irq_pending, .tx_bit0, .tx_bit1, .tx_drive0, .tx_drive1,
      .cpu_stop, .rx_bit, .line0_to_ref, .line1_to_ref, .sleep_ref_select,
      .active_cmp_en, .sleep_cmp_en, .can_asleep_flag, .wake_irq, .can_clk_en,
      .cpu_clk_en, .osc_stop, .tx_line0_out, .tx_line0_oe, .tx_line1_out,
      .tx_line1_oe);
   crs_bus_node i_node (.clk, .node_dom, .stuck0, .stuck1, .cmp_blind, .tx0_out(tx_line0_out),
      .tx0_oe(tx_line0_oe), .tx1_out(tx_line1_out), .tx1_oe(tx_line1_oe),
      .line0(line0_in), .line1(line1_in), .cmp0(sleep_cmp0_in),
      .cmp1(sleep_cmp1_in), .frame_valid(rx_frame_valid), .frame(rx_frame));

   always #50 clk = ~clk;

   function automatic logic [7:0] ftl(crs_frame_t x);
      return {x.id[2:0], x.rtr, x.dlc};
   endfunction
   function automatic int cnt(crs_frame_t x);
      // Codes above eight still move only eight bytes
      return x.rtr ? 0 : (x.dlc > DLC_MAX) ? int'(DLC_MAX) : int'(x.dlc);
   endfunction
   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      v = rd_data;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic frame_test(input crs_frame_t fr);
      logic [7:0] v;
      i_node.send(fr);
      vis = ~vis;
      for (int i = 0; i < cnt(fr); i++) exp_set[vis][i] = fr.data[i];
      wr(8'h34 + 8'($urandom_range(0, 9)), 8'($urandom));
      rd(ADDR_RX_ID_HIGH, v);
      chk("id_high", v, fr.id[10:3]);
      rd(ADDR_RX_FTL, v);
      chk("ftl", v, ftl(fr));
      for (int i = 0; i < DATA_BYTES; i++) begin
         rd(ADDR_RX_DATA_FIRST + 8'(i), v);
         chk("data", v, exp_set[vis][i]);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Whole run is under a thousand cycles; this leaves a wide margin
   initial begin
      #2000000;
      bad_count++;
      report_and_stop();
   end

   initial begin
      clk = 0;
      resetn = 0;
      ce = 1;
      addr = 0;
      wr_data = 0;
      wr_en = 0;
      rd_en = 0;
      irq_pending = 0;
      cpu_stop = 0;
      tx_bit0 = 1;
      tx_bit1 = 1;
      tx_drive0 = 0;
      tx_drive1 = 0;
      node_dom = 0;
      stuck0 = 0;
      stuck1 = 0;
      cmp_blind = 0;
      bad_count = 0;
      checks_done = 0;
      vis = 0;
      void'($urandom(15));
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      for (int k = 0; k < 23; k++) begin
         f = {11'($urandom), 1'b0, 4'h8, $urandom, $urandom};
         if (k == 2) f.rtr = 1'b1;
         if (k > 2) begin
            f.rtr = ($urandom_range(0, 3) == 0);
            f.dlc = 4'($urandom_range(0, 8));
         end
         if (k == 3) f = {f.id, 1'b0, 4'hf, f.data};
         frame_test(f);
      end
      rd(8'h40, d);
      chk("unmapped", d, 0);
      @(posedge clk);
      node_dom <= 1'b1;
      cyc(2);
      chk("rx_bit node", rx_bit, DOMINANT);
      node_dom <= 1'b0;
      tx_drive0 <= 1'b1;
      tx_bit0 <= 1'b0;
      tx_bit1 <= 1'b0;
      cyc(3);
      chk("own drive", {tx_line0_oe, tx_line0_out, rx_bit}, 3'b100);
      chk("tx1 idle", {tx_line1_oe, tx_line1_out}, 2'b00);
      tx_drive0 <= 1'b0;
      tx_bit0 <= 1'b1;
      tx_bit1 <= 1'b1;
      stuck0 <= 1'b1;
      cyc(2);
      chk("rx_bit stuck", rx_bit, DOMINANT);
      // Faulted line stays undriven while it sits on the reference
      wr(ADDR_CMD, 8'h02);
      cyc(1);
      chk("passive", {line0_to_ref, line1_to_ref, rx_bit}, 3'b101);
      node_dom <= 1'b1;
      cyc(2);
      chk("one wire", rx_bit, DOMINANT);
      node_dom <= 1'b0;
      stuck0 <= 1'b0;
      stuck1 <= 1'b1;
      wr(ADDR_CMD, 8'h04);
      cyc(1);
      chk("line1 ref", {line0_to_ref, line1_to_ref, rx_bit}, 3'b011);
      node_dom <= 1'b1;
      wr(ADDR_CMD, 8'h06);
      cyc(1);
      chk("both ref", rx_bit, RECESSIVE);
      node_dom <= 1'b0;
      stuck1 <= 1'b0;
      wr(ADDR_CMD, 8'h00);
      irq_pending <= 1'b1;
      wr(ADDR_CMD, 8'h01);
      chk("busy irq", {wake_irq, can_asleep_flag}, 2'b10);
      irq_pending <= 1'b0;
      node_dom <= 1'b1;
      wr(ADDR_CMD, 8'h01);
      chk("busy bus", {wake_irq, can_asleep_flag}, 2'b10);
      node_dom <= 1'b0;
      tx_drive0 <= 1'b1;
      tx_drive1 <= 1'b1;
      wr(ADDR_CMD, 8'h01);
      chk("asleep", {can_asleep_flag, wake_irq}, 2'b10);
      chk("clocks", {can_clk_en, cpu_clk_en}, 2'b01);
      chk("tx off", {tx_line0_oe, tx_line1_oe}, 2'b00);
      chk("cmps", {active_cmp_en, sleep_cmp_en}, 2'b01);
      rd(ADDR_CMD, d);
      chk("cmd read", d[CMD_SLEEP_BIT], 0);
      rd(ADDR_STAT, d);
      chk("status", d[STAT_ASLEEP_BIT], 1);
      cpu_stop <= 1'b1;
      cyc(5);
      wr(ADDR_CMD, 8'h00);
      chk("sw wake", {can_asleep_flag, wake_irq, can_clk_en}, 3'b001);
      chk("cpu clk", cpu_clk_en, 0);
      n = 0;
      repeat (30) begin
         cyc(1);
         if (osc_stop === 1'b1) n++;
      end
      chk("osc held", n, 0);
      wr(ADDR_CMD, 8'h01);
      for (n = 0; n < 40 && osc_stop !== 1'b1; n++) cyc(1);
      // One cycle into the wait state, then the full stop delay
      chk("osc off", {osc_stop, n == int'(OSC_STOP_DELAY_CYC) + 1}, 2'b11);
      @(posedge clk);
      node_dom <= 1'b1;
      cyc(1);
      chk("bus wake", {wake_irq, can_asleep_flag, can_clk_en}, 3'b101);
      chk("osc back", osc_stop, 0);
      cyc(1);
      chk("irq pulse", wake_irq, 0);
      node_dom <= 1'b0;
      cpu_stop <= 1'b0;
      wr(ADDR_CMD, 8'h09);
      cyc(1);
      chk("ref sel", {sleep_ref_select, can_asleep_flag}, 2'b11);
      cmp_blind <= 1'b1;
      node_dom <= 1'b1;
      cyc(3);
      chk("half ref", can_asleep_flag, 1);
      cmp_blind <= 1'b0;
      cyc(1);
      chk("ref wake", {wake_irq, can_asleep_flag}, 2'b10);
      node_dom <= 1'b0;
      cyc(2);
      report_and_stop();
   end
endmodule
